/* imcfg_top.sv */
// APB register bank holding the locked immobilizer options and their link-side decode.
// Assumes an APB master on pclk and a free-running field clock on link_clk.
//
// Functional notes
// - Options live in NVM page 2 and become read-only once locked.
// - Unused key area words serve as general variable storage.
// - Option bit 0 low enables CRC both ways; high disables both.
// - CRC setting applies to every request received and response sent.
// - Option bit 2 low gives unilateral, high bilateral authentication.
// - Crypto mode is evaluated on authentication and memory access commands.
// - Expected challenge bit count comes from the query length byte.
// - Reply bit count equals the reply length byte.
// - Option bit 1 picks uplink Manchester (0) or biphase (1).
// - Option bits 4:3 pick binary, quad or third downlink decoding.
// - Option bit 5 picks key one or key two.
// - Option bit 7 includes the detection header at initialization.
`timescale 1ns/100ps
`default_nettype none
module imcfg_top (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Field link domain
   input wire logic link_clk,
   input wire logic link_rstn,
   input wire logic cmd_valid,
   input wire logic cmd_is_auth,
   input wire logic cmd_is_mem,
   input wire logic cmd_crc_ok,
   // Decoded settings for the field-side engines
   output imcfg_pkg::imcfg_cfg_t link_cfg,
   output logic link_ready,
   output logic link_crc_check,
   output logic link_crc_append,
   output logic link_bilateral,
   output logic link_respond,
   output logic link_cmd_drop
);
   import imcfg_pkg::*;

   logic [7:0] option_byte;
   logic [7:0] query_length;
   logic [7:0] reply_length;
   logic locked;
   logic loaded;
   logic [31:0] scratch [IMCFG_SCRATCH_WORDS];

   // Index decode; the byte address is four times the index.
   wire logic [11:0] idx = paddr[13:2];
   wire logic setup = psel && !penable;
   wire logic access = psel && penable;
   wire logic hit_opt = (idx == IMCFG_IDX_OPTION);
   wire logic hit_qlen = (idx == IMCFG_IDX_QLEN);
   wire logic hit_rlen = (idx == IMCFG_IDX_RLEN);
   wire logic hit_ctrl = (idx == IMCFG_IDX_CTRL);
   wire logic hit_stat = (idx == IMCFG_IDX_STAT);
   wire logic [11:0] scr_off = idx - IMCFG_IDX_SCRATCH;
   wire logic hit_scr = (idx >= IMCFG_IDX_SCRATCH) &&
                        (scr_off < 12'(IMCFG_SCRATCH_WORDS));
   wire logic [3:0] scr_idx = scr_off[3:0];
   wire logic hit_any = hit_opt || hit_qlen || hit_rlen || hit_ctrl || hit_stat || hit_scr;
   // Writes to option bytes after locking are refused with an error.
   wire logic cfg_hit = hit_opt || hit_qlen || hit_rlen;
   wire logic bad = !hit_any || (pwrite && (hit_stat || (cfg_hit && locked)));
   // A write lands at the access edge at which pready is sampled high, as the master expects.
   wire logic do_wr = access && pready && pwrite && !bad;
   wire logic wr_opt = do_wr && hit_opt;
   wire logic wr_qlen = do_wr && hit_qlen;
   wire logic wr_rlen = do_wr && hit_rlen;
   wire logic wr_lock = do_wr && hit_ctrl && pwdata[IMCFG_B_LOCK];

   wire logic [31:0] rd_mux =
      hit_opt ? {24'h00_0000, option_byte} :
      hit_qlen ? {24'h00_0000, query_length} :
      hit_rlen ? {24'h00_0000, reply_length} :
      hit_ctrl ? {31'h0000_0000, locked} :
      hit_stat ? {30'h0000_0000, loaded, locked} :
      hit_scr ? scratch[scr_idx] : IMCFG_ZERO;

   // The slave answers one cycle after setup: pready rises in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= IMCFG_ZERO;
      end else begin
         pready <= setup;
         pslverr <= setup && bad;
         prdata <= (setup && !pwrite && !bad) ? rd_mux : IMCFG_ZERO;
      end
   end

   // Page 2 content: writable any number of times during validation, then locked until the next bus reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         option_byte <= IMCFG_RESET_BYTE;
         query_length <= IMCFG_RESET_BYTE;
         reply_length <= IMCFG_RESET_BYTE;
         locked <= 1'b0;
      end else if (do_wr) begin
         if (wr_opt) option_byte <= pwdata[7:0];
         if (wr_qlen) query_length <= pwdata[7:0];
         if (wr_rlen) reply_length <= pwdata[7:0];
         if (wr_lock) locked <= 1'b1;
      end
   end

   // Unassigned key area words as variable storage.
   genvar gi;
   generate
      for (gi = 0; gi < IMCFG_SCRATCH_WORDS; gi++) begin : g_scr
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) scratch[gi] <= IMCFG_ZERO;
            else if (do_wr && hit_scr && scr_idx == 4'(gi)) scratch[gi] <= pwdata;
         end
      end
   endgenerate

   // The lock event is the trigger for handing the set to the link side.
   // The bytes are stable once locked, so a synchronised level qualifies them.
   logic lock_s1;
   logic lock_s2;
   logic loaded_s1;
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end else begin
         lock_s1 <= locked;
         lock_s2 <= lock_s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_s1 <= 1'b0;
         loaded <= 1'b0;
      end else begin
         loaded_s1 <= link_ready;
         loaded <= loaded_s1;
      end
   end

   // Link side: wait for the lock, then run on the captured set.
   // A bus reset drops the lock, so the link side stops answering until the set is
   // locked again rather than run on a copy that may no longer match page 2.
   typedef enum logic [1:0] {
      LINK_WAIT,
      LINK_RUN
   } imcfg_link_state_t;

   imcfg_link_state_t link_state;
   imcfg_link_state_t next_link_state;

   always_comb begin
      next_link_state = link_state;
      case (link_state)
         LINK_WAIT: if (lock_s2) next_link_state = LINK_RUN;
         LINK_RUN: if (!lock_s2) next_link_state = LINK_WAIT;
         default: next_link_state = LINK_WAIT;
      endcase
   end

   wire imcfg_opt_t opt_in = option_byte;
   wire logic capture = (link_state == LINK_WAIT) && lock_s2;
   wire logic crc_on = !link_cfg.opt.crc_disable;
   wire logic needs_mode = cmd_is_auth || cmd_is_mem;
   wire logic reject = crc_on && !cmd_crc_ok;
   wire logic cmd_live = cmd_valid && link_ready;
   wire logic take_mode = cmd_live && needs_mode;
   // Commands before the options are latched are dropped.
   wire logic next_respond = cmd_live && !reject;
   wire logic next_drop = cmd_valid && (!link_ready || reject);
   wire logic next_crc_on = link_ready && crc_on;

   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         link_state <= LINK_WAIT;
         link_ready <= 1'b0;
      end else begin
         link_state <= next_link_state;
         link_ready <= (next_link_state == LINK_RUN);
      end
   end

   // The bytes do not move while the lock holds, so one copy per lock is enough.
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         link_cfg <= '0;
      end else if (capture) begin
         link_cfg <= {opt_in, query_length, reply_length};
      end
   end

   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         link_crc_check <= 1'b0;
         link_crc_append <= 1'b0;
      end else begin
         link_crc_check <= next_crc_on;
         link_crc_append <= next_crc_on;
      end
   end

   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         link_bilateral <= 1'b0;
         link_respond <= 1'b0;
         link_cmd_drop <= 1'b0;
      end else begin
         if (take_mode) link_bilateral <= link_cfg.opt.crypto_mode;
         link_respond <= next_respond;
         link_cmd_drop <= next_drop;
      end
   end
endmodule : imcfg_top
`default_nettype wire

/* imcfg_pkg.sv */
// Package for the immobilizer configuration option bank.
// Assumes a 20 MHz APB clock and a separate field-derived link clock.
package imcfg_pkg;
   // Printed byte addresses are not multiples of four, so they are kept as indices.
   localparam logic [11:0] IMCFG_IDX_OPTION = 12'h0815;
   localparam logic [11:0] IMCFG_IDX_QLEN = 12'h0819;
   localparam logic [11:0] IMCFG_IDX_RLEN = 12'h081a;
   localparam logic [11:0] IMCFG_IDX_CTRL = 12'h0840;
   localparam logic [11:0] IMCFG_IDX_STAT = 12'h0841;
   localparam logic [11:0] IMCFG_IDX_SCRATCH = 12'h07e0;
   localparam int IMCFG_SCRATCH_WORDS = 16;
   localparam int IMCFG_NVM_PAGE = 2;
   // Bit positions inside the option byte.
   localparam int IMCFG_B_CRC_DIS = 0;
   localparam int IMCFG_B_UPLINK = 1;
   localparam int IMCFG_B_DL_LO = 3;
   localparam int IMCFG_B_DL_HI = 4;
   localparam int IMCFG_B_CRYPTO = 2;
   localparam int IMCFG_B_KEYSEL = 5;
   localparam int IMCFG_B_SKT = 6;
   localparam int IMCFG_B_TDH = 7;
   // Control and status bits.
   localparam int IMCFG_B_LOCK = 0;
   localparam int IMCFG_B_LOADED = 1;
   localparam logic [7:0] IMCFG_RESET_BYTE = 8'h00;
   localparam logic [31:0] IMCFG_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      IMCFG_DL_BINARY = 2'b00,
      IMCFG_DL_QUAD = 2'b01,
      IMCFG_DL_THIRD = 2'b10
   } imcfg_dl_t;
   typedef struct packed {
      logic detection_header_on;
      logic secure_key_transfer;
      logic key_select;
      logic [1:0] downlink_coding;
      logic crypto_mode;
      logic uplink_coding;
      logic crc_disable;
   } imcfg_opt_t;
   typedef struct packed {
      imcfg_opt_t opt;
      logic [7:0] query_length_bits;
      logic [7:0] response_length_bits;
   } imcfg_cfg_t;
endpackage : imcfg_pkg

/* imcfg_monitor.sv */
// Checker for the option bank, seeing only the ports of imcfg_top.
// Assumes it is bound to every imcfg_top instance.
`timescale 1ns/100ps
`default_nettype none
module imcfg_monitor (
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Field side
   input wire logic link_clk,
   input wire logic link_rstn,
   input wire logic cmd_valid,
   input wire logic cmd_is_auth,
   input wire logic cmd_is_mem,
   input wire logic cmd_crc_ok,
   input wire imcfg_pkg::imcfg_cfg_t link_cfg,
   input wire logic link_ready,
   input wire logic link_crc_check,
   input wire logic link_crc_append,
   input wire logic link_bilateral,
   input wire logic link_respond,
   input wire logic link_cmd_drop
);
   import imcfg_pkg::*;
   a_setup_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready) else $error("setup not answered");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready held");
   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready) else $error("pslverr alone");
   a_crc_check_bit: assert property (@(posedge link_clk) disable iff (!link_rstn)
      link_crc_check == $past(link_ready && !link_cfg.opt.crc_disable)) else $error("crc check");
   a_crc_both_ways: assert property (@(posedge link_clk) disable iff (!link_rstn)
      link_crc_append == link_crc_check) else $error("crc append");
   a_one_answer: assert property (@(posedge link_clk) disable iff (!link_rstn)
      cmd_valid |=> link_respond != link_cmd_drop) else $error("answer count");
   a_bad_crc_drop: assert property (@(posedge link_clk) disable iff (!link_rstn)
      cmd_valid && link_crc_check && !cmd_crc_ok |=> link_cmd_drop) else $error("bad crc");
   a_early_drop: assert property (@(posedge link_clk) disable iff (!link_rstn)
      cmd_valid && !link_ready |=> link_cmd_drop) else $error("early command");
   a_mode_capture: assert property (@(posedge link_clk) disable iff (!link_rstn)
      cmd_valid && link_ready && (cmd_is_auth || cmd_is_mem)
      |=> link_bilateral == link_cfg.opt.crypto_mode) else $error("crypto mode");
endmodule : imcfg_monitor
bind imcfg_top imcfg_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
   .link_rstn(link_rstn), .cmd_valid(cmd_valid), .cmd_is_auth(cmd_is_auth),
   .cmd_is_mem(cmd_is_mem), .cmd_crc_ok(cmd_crc_ok), .link_cfg(link_cfg),
   .link_ready(link_ready), .link_crc_check(link_crc_check), .link_crc_append(link_crc_append),
   .link_bilateral(link_bilateral), .link_respond(link_respond), .link_cmd_drop(link_cmd_drop));
`default_nettype wire

/* imcfg_base_stn.sv */
// Base station model: sends request frames on the field clock.
// Assumes a free-running link_clk; the answer pulse is read one edge after the frame.
`timescale 1ns/100ps
`default_nettype none
module imcfg_base_stn (
   // Field side
   input wire logic link_clk,
   input wire logic link_respond,
   output logic cmd_valid = 1'b0,
   output logic cmd_is_auth = 1'b1,
   output logic cmd_is_mem = 1'b1,
   output logic cmd_crc_ok = 1'b0
);
   // Challenge and reply lengths are taken as matching the stored ones.
   task automatic send(input logic auth, mem, crc, output logic resp);
      @(posedge link_clk);
      cmd_valid <= 1'b1;
      cmd_is_auth <= auth;
      cmd_is_mem <= mem;
      cmd_crc_ok <= crc;
      @(posedge link_clk);
      cmd_valid <= 1'b0;
      // Released qualifiers turn over so a stale value is never mistaken for a live one.
      cmd_is_auth <= ~auth;
      cmd_is_mem <= ~mem;
      cmd_crc_ok <= ~crc;
      #1 resp = link_respond;
   endtask : send
endmodule : imcfg_base_stn
`default_nettype wire

/* tb_immobilizer_config_options.sv */
// Testbench for the option bank: APB tasks and field commands via the base station.
// Assumes imcfg_top, its checker and imcfg_base_stn are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_immobilizer_config_options;
   import imcfg_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, link_clk = 0, link_rstn = 0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, cmd_valid, cmd_is_auth, cmd_is_mem, cmd_crc_ok, r;
   logic link_ready, link_crc_check, link_crc_append, link_bilateral, link_respond, link_cmd_drop;
   imcfg_cfg_t link_cfg;
   int n_fail = 0, checked = 0, cyc = 0;
   logic [7:0] opts [2] = '{8'h85, 8'h52};
   always #25 pclk = ~pclk;
   always #3 link_clk = ~link_clk;
   imcfg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk(link_clk), .link_rstn(link_rstn), .cmd_valid(cmd_valid),
      .cmd_is_auth(cmd_is_auth), .cmd_is_mem(cmd_is_mem), .cmd_crc_ok(cmd_crc_ok),
      .link_cfg(link_cfg), .link_ready(link_ready), .link_crc_check(link_crc_check),
      .link_crc_append(link_crc_append), .link_bilateral(link_bilateral),
      .link_respond(link_respond), .link_cmd_drop(link_cmd_drop));
   imcfg_base_stn u_bs (.link_clk(link_clk), .link_respond(link_respond), .cmd_valid(cmd_valid),
      .cmd_is_auth(cmd_is_auth), .cmd_is_mem(cmd_is_mem), .cmd_crc_ok(cmd_crc_ok));
   task automatic check(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd, exp,
      input logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= 16'({idx, 2'b00});
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!wr) check(prdata, exp);
      check(32'(pslverr), 32'(err));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic final_report;
      $display("checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   always @(posedge pclk) if (++cyc == 3000) begin
      n_fail++;
      final_report;
   end
   initial begin
      foreach (opts[k]) begin
         presetn <= 1'b0;
         link_rstn <= 1'b0;
         repeat (5) @(posedge pclk);
         presetn <= 1'b1;
         link_rstn <= 1'b1;
         apb(0, IMCFG_IDX_OPTION, 0, 0, 0);
         u_bs.send(1, 0, 1, r);
         check(r, 0);
         apb(1, IMCFG_IDX_OPTION, opts[k], 0, 0);
         apb(1, IMCFG_IDX_QLEN, 32'h0000_0040 + k, 0, 0);
         apb(1, IMCFG_IDX_RLEN, 32'h0000_0080, 0, 0);
         apb(1, IMCFG_IDX_SCRATCH + 12'(k), 32'hcafe_0000, 0, 0);
         apb(0, IMCFG_IDX_SCRATCH + 12'(k), 0, 32'hcafe_0000, 0);
         apb(0, 12'h0900, 0, 0, 1);
         apb(1, IMCFG_IDX_CTRL, 1, 0, 0);
         repeat (10) @(posedge pclk);
         apb(0, IMCFG_IDX_STAT, 0, 3, 0);
         apb(1, IMCFG_IDX_OPTION, 0, 0, 1);
         apb(0, IMCFG_IDX_OPTION, 0, opts[k], 0);
         check(link_cfg, {opts[k], 8'h40 + 8'(k), 8'h80});
         check(link_crc_check, !opts[k][0]);
         check(link_crc_append, !opts[k][0]);
         u_bs.send(1, 0, 0, r);
         check(r, opts[k][0]);
         check(link_bilateral, opts[k][2]);
         u_bs.send(0, 1, 1, r);
         check(r, 1);
         $display("test %0d done", k);
      end
      final_report;
   end
endmodule : tb_immobilizer_config_options
`default_nettype wire
